// ### rtl/host_cmd_pkg.sv
/*
  Constants shared by the host command block: register offsets, command and
  reply codes, field positions, reset values and timing in 1/32 second ticks.
  Assumes a 10 MHz system clock.
*/
package host_cmd_pkg;
  // register byte offsets
  localparam logic [3:0] OFS_CMD = 4'h0;
  localparam logic [3:0] OFS_RESP_HDR = 4'h4;
  localparam logic [3:0] OFS_RESP_DATA = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;
  // command codes and reply flags
  localparam logic [7:0] CMD_CONTRAST = 8'h0D;
  localparam logic [7:0] CMD_BACKLIGHT = 8'h0E;
  localparam logic [7:0] CMD_KEY_REPORT = 8'h17;
  localparam logic [7:0] CMD_KEY_POLL = 8'h18;
  localparam logic [7:0] CMD_POWER_CTRL = 8'h1C;
  localparam logic [7:0] CMD_WATCHDOG = 8'h1D;
  localparam logic [7:0] REPLY_FLAG = 8'h40;
  localparam logic [7:0] ERROR_FLAG = 8'hC0;
  localparam logic [7:0] CODE_MASK = 8'h3F;
  // value limits
  localparam logic [7:0] BRIGHT_MAX = 8'h64;
  localparam logic [7:0] MASK_MAX = 8'h3F;
  localparam logic [7:0] PULSE_HOLD = 8'hFF;
  localparam logic [7:0] PULSE_ZERO = 8'h00;
  // reset values
  localparam logic [7:0] CONTRAST_RST = 8'h7F;
  localparam logic [6:0] BRIGHT_RST = 7'h64;
  localparam logic [5:0] KEY_MASK_RST = 6'h3F;
  localparam logic [7:0] POWER_FN_RST = 8'h01;
  localparam logic [7:0] PULSE_LEN_RST = 8'hFF;
  // key bit positions
  localparam int KEY_ENTER = 1;
  localparam int KEY_CANCEL = 2;
  // power-control function bits
  localparam int FN_AUTO_POL = 0;
  localparam int FN_RESET_HIGH = 1;
  localparam int FN_POWER_HIGH = 2;
  localparam int FN_LEDS_FOLLOW = 3;
  localparam int FN_DISPLAY_FOLLOW = 4;
  localparam int FN_KEY_RESET = 5;
  localparam int FN_KEY_POWER_ON = 6;
  localparam int FN_KEY_POWER_OFF = 7;
  // status and response header bits
  localparam int ST_BUSY = 0;
  localparam int ST_SENSE = 1;
  localparam int ST_KEYS_LSB = 8;
  localparam int RESP_VALID_BIT = 16;
  // timing: one tick is 1/32 second
  localparam longint CLK_PERIOD_NS = 100;
  localparam longint TICK_NS = 31_250_000;
  localparam int TICK_CYCLES = int'(TICK_NS / CLK_PERIOD_NS);
  localparam int TICK_W = 20;
  localparam logic [12:0] SEC_TICKS = 13'h0020;
  localparam logic [7:0] HOLD_LONG_TICKS = 8'h80;
  localparam logic [7:0] HOLD_SHORT_TICKS = 8'h08;
  localparam logic [8:0] RESET_PULSE_TICKS = 9'h020;
  localparam logic [8:0] PULSE_HOLD_MAX_TICKS = 9'h100;
  localparam logic [7:0] EXTEND_TICKS = 8'hA0;
  localparam logic [8:0] RESTART_TICKS = 9'h020;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PULSE = 3'b010,
    ST_RESTART = 3'b100
  } mode_t;
endpackage : host_cmd_pkg

// ### rtl/host_cmd_keypad_power_watchdog.sv
/*
  Command interpreter for contrast, backlights, key reporting, polled keypad,
  host power/reset control and host watchdog, reached over Avalon-MM.
  Assumes key and sense pins are asynchronous (synchronised here), keys read
  high while pressed, and the host line pins are resolved by the surroundings.
*/
`timescale 1ns/1ps
module host_cmd_keypad_power_watchdog #(
  parameter int TICK_CYCLES = host_cmd_pkg::TICK_CYCLES
) (
  input wire logic sys_clk, // 10 MHz clock
  input wire logic rst_n, // async reset, active low
  input wire logic clk_en, // freezes all state while low
  input wire logic [3:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic [5:0] key_pins, // keys, high while pressed
  input wire logic host_sense_pin, // host power sense
  output logic reset_line_o, // host reset line level
  output logic reset_line_oe, // host reset line driven
  output logic power_line_o, // host power line level
  output logic power_line_oe, // host power line driven
  output logic [7:0] contrast_level, // display contrast
  output logic [6:0] display_brightness, // display backlight 0-100
  output logic [6:0] keypad_brightness, // keypad backlight 0-100
  output logic display_on, // display not blanked
  output logic leds_on, // front leds allowed
  output logic [5:0] key_press_report, // one-cycle press events
  output logic [5:0] key_release_report, // one-cycle release events
  output logic restarting // module restart in progress
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [7:0] contrast;
    logic [6:0] disp_bl;
    logic [6:0] key_bl;
    logic [5:0] press_mask;
    logic [5:0] release_mask;
    logic [7:0] power_fn;
    logic [7:0] pulse_len;
    logic [7:0] wd_timeout;
    logic [12:0] wd_ticks;
    logic [7:0] resp_type;
    logic [1:0] resp_len;
    logic [23:0] resp_data;
    logic resp_valid;
    logic [5:0] keys_s1;
    logic [5:0] keys_s2;
    logic sense_s1;
    logic sense_s2;
    logic sense_prev;
    logic [5:0] keys_prev;
    logic [5:0] pressed_acc;
    logic [5:0] released_acc;
    logic [5:0] rep_press;
    logic [5:0] rep_release;
    logic [host_cmd_pkg::TICK_W-1:0] tick_cnt;
    logic tick;
    logic [7:0] confirm_ticks;
    logic [7:0] cancel_ticks;
    logic wait_release;
    host_cmd_pkg::mode_t mode;
    logic pulse_power;
    logic hold_ext;
    logic restart_after;
    logic pulse_sense;
    logic [8:0] pulse_ticks;
    logic [7:0] ext_ticks;
    logic rst_drive;
    logic pwr_drive;
    logic rst_level;
    logic pwr_level;
    logic disp_en;
    logic leds_en;
    logic [6:0] disp_out;
    logic [6:0] key_out;
  } regs_t;

  localparam logic [host_cmd_pkg::TICK_W-1:0] TICK_LAST = host_cmd_pkg::TICK_W'(TICK_CYCLES - 1);

  regs_t r;
  regs_t next_r;

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake: one stall cycle, write lands and read data stands at ack

  assign avs_waitrequest = (avs_read | avs_write) & ~r.ack;
  assign avs_readdata = r.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [5:0] rise;
    logic [5:0] fall;
    logic [7:0] typ;
    logic [1:0] len;
    logic [7:0] d0;
    logic [7:0] d1;
    logic err;
    logic cmd_go;
    logic wd_expire;
    logic confirm_held;
    logic cancel_held;
    logic host_off;
    logic start;
    logic [8:0] lim;
    logic base_done;
    rise = '0;
    fall = '0;
    typ = '0;
    len = '0;
    d0 = '0;
    d1 = '0;
    err = 1'b0;
    cmd_go = 1'b0;
    wd_expire = 1'b0;
    start = 1'b0;
    lim = '0;
    base_done = 1'b0;
    confirm_held = 1'b0;
    cancel_held = 1'b0;
    host_off = 1'b0;
    next_r = r;

    // pin synchronisers and tick
    next_r.keys_s1 = key_pins;
    next_r.keys_s2 = r.keys_s1;
    next_r.sense_s1 = host_sense_pin;
    next_r.sense_s2 = r.sense_s1;
    next_r.sense_prev = r.sense_s2;
    next_r.tick = (r.tick_cnt == TICK_LAST);
    next_r.tick_cnt = next_r.tick ? '0 : r.tick_cnt + 1'b1;
    confirm_held = r.keys_s2[host_cmd_pkg::KEY_ENTER];
    cancel_held = r.keys_s2[host_cmd_pkg::KEY_CANCEL];

    // key edges, reports and poll accumulators
    rise = r.keys_s2 & ~r.keys_prev;
    fall = ~r.keys_s2 & r.keys_prev;
    next_r.keys_prev = r.keys_s2;
    next_r.rep_press = rise & r.press_mask;
    next_r.rep_release = fall & r.release_mask;
    next_r.pressed_acc = r.pressed_acc | rise;
    next_r.released_acc = r.released_acc | fall;

    // bus access
    next_r.ack = (avs_read | avs_write) & ~r.ack;
    if (avs_read & ~r.ack) begin
      case (avs_address)
        host_cmd_pkg::OFS_RESP_HDR: begin
          next_r.rdata = '0;
          next_r.rdata[7:0] = r.resp_type;
          next_r.rdata[9:8] = r.resp_len;
          next_r.rdata[host_cmd_pkg::RESP_VALID_BIT] = r.resp_valid;
        end
        host_cmd_pkg::OFS_RESP_DATA: next_r.rdata = {8'h00, r.resp_data};
        host_cmd_pkg::OFS_STATUS: begin
          next_r.rdata = '0;
          next_r.rdata[host_cmd_pkg::ST_BUSY] = (r.mode != host_cmd_pkg::ST_IDLE);
          next_r.rdata[host_cmd_pkg::ST_SENSE] = r.sense_s2;
          next_r.rdata[host_cmd_pkg::ST_KEYS_LSB +: 6] = r.keys_s2;
        end
        default: next_r.rdata = '0;
      endcase
    end
    // commands are dropped while pulsing or restarting
    cmd_go = avs_write & r.ack & (avs_address == host_cmd_pkg::OFS_CMD) & (&avs_byteenable)
             & (r.mode == host_cmd_pkg::ST_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // command decode
    if (cmd_go) begin
      typ = avs_writedata[7:0];
      len = avs_writedata[9:8];
      d0 = avs_writedata[23:16];
      d1 = avs_writedata[31:24];
      next_r.resp_len = '0;
      next_r.resp_data = '0;
      case (typ)
        host_cmd_pkg::CMD_CONTRAST: begin
          if (len == 2'd0) begin
            next_r.resp_len = 2'd1;
            next_r.resp_data[7:0] = r.contrast;
          end else if (len == 2'd1) next_r.contrast = d0;
          else err = 1'b1;
        end
        host_cmd_pkg::CMD_BACKLIGHT: begin
          if (len == 2'd0) begin
            next_r.resp_len = 2'd2;
            next_r.resp_data[15:0] = {1'b0, r.key_bl, 1'b0, r.disp_bl};
          end else if (len == 2'd1 && d0 <= host_cmd_pkg::BRIGHT_MAX) begin
            next_r.disp_bl = d0[6:0];
            next_r.key_bl = d0[6:0];
          end else if (len == 2'd2 && d0 <= host_cmd_pkg::BRIGHT_MAX && d1 <= host_cmd_pkg::BRIGHT_MAX) begin
            next_r.disp_bl = d0[6:0];
            next_r.key_bl = d1[6:0];
          end else err = 1'b1;
        end
        host_cmd_pkg::CMD_KEY_REPORT: begin
          if (len == 2'd0) begin
            next_r.resp_len = 2'd2;
            next_r.resp_data[15:0] = {2'b00, r.release_mask, 2'b00, r.press_mask};
          end else if (len == 2'd2 && d0 <= host_cmd_pkg::MASK_MAX && d1 <= host_cmd_pkg::MASK_MAX) begin
            next_r.press_mask = d0[5:0];
            next_r.release_mask = d1[5:0];
          end else err = 1'b1;
        end
        host_cmd_pkg::CMD_KEY_POLL: begin
          if (len == 2'd0) begin
            next_r.resp_len = 2'd3;
            next_r.resp_data = {2'b00, r.released_acc, 2'b00, r.pressed_acc, 2'b00, r.keys_s2};
            // an edge in this very cycle is kept for the next poll
            next_r.pressed_acc = rise;
            next_r.released_acc = fall;
          end else err = 1'b1;
        end
        host_cmd_pkg::CMD_POWER_CTRL: begin
          if (len == 2'd0) begin
            next_r.resp_len = 2'd2;
            next_r.resp_data[15:0] = {r.pulse_len, r.power_fn};
          end else if (len == 2'd1) next_r.power_fn = d0;
          else if (len == 2'd2 && d1 != host_cmd_pkg::PULSE_ZERO) begin
            next_r.power_fn = d0;
            next_r.pulse_len = d1;
          end else err = 1'b1;
        end
        host_cmd_pkg::CMD_WATCHDOG: begin
          if (len == 2'd0) begin
            next_r.resp_len = 2'd1;
            next_r.resp_data[7:0] = r.wd_timeout;
          end else if (len == 2'd1) begin
            next_r.wd_timeout = d0;
            next_r.wd_ticks = '0;
          end else err = 1'b1;
        end
        default: err = 1'b1;
      endcase
      next_r.resp_valid = 1'b1;
      if (err) begin
        next_r.resp_len = '0;
        next_r.resp_data = '0;
        next_r.resp_type = host_cmd_pkg::ERROR_FLAG | (typ & host_cmd_pkg::CODE_MASK);
      end else next_r.resp_type = host_cmd_pkg::REPLY_FLAG | typ;
    end

    ////////////////////////////////////////////////////////////////////////
    // watchdog: counts seconds as 32 ticks each
    if (r.wd_timeout != 8'h00 && r.tick && !cmd_go) begin
      next_r.wd_ticks = r.wd_ticks + 1'b1;
      wd_expire = (next_r.wd_ticks >= 13'(13'(r.wd_timeout) * host_cmd_pkg::SEC_TICKS));
    end

    // key hold timers, rearmed only after both keys are let go
    if (r.wait_release) begin
      next_r.confirm_ticks = '0;
      next_r.cancel_ticks = '0;
      if (!confirm_held && !cancel_held && r.mode == host_cmd_pkg::ST_IDLE) next_r.wait_release = 1'b0;
    end else if (r.tick) begin
      next_r.confirm_ticks = !confirm_held ? 8'h00 : (&r.confirm_ticks ? r.confirm_ticks : r.confirm_ticks + 1'b1);
      next_r.cancel_ticks = !cancel_held ? 8'h00 : (&r.cancel_ticks ? r.cancel_ticks : r.cancel_ticks + 1'b1);
    end else begin
      if (!confirm_held) next_r.confirm_ticks = '0;
      if (!cancel_held) next_r.cancel_ticks = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // host line sequencer
    case (r.mode)
      host_cmd_pkg::ST_IDLE: begin
        if (wd_expire) begin
          start = 1'b1;
          next_r.pulse_power = 1'b0;
          next_r.restart_after = 1'b1;
          next_r.wd_timeout = '0;
        end else if (r.power_fn[host_cmd_pkg::FN_DISPLAY_FOLLOW] && r.sense_s2 && !r.sense_prev) begin
          next_r.mode = host_cmd_pkg::ST_RESTART;
          next_r.pulse_ticks = '0;
        end else if (r.power_fn[host_cmd_pkg::FN_KEY_RESET] && r.sense_s2
                     && r.confirm_ticks >= host_cmd_pkg::HOLD_LONG_TICKS) begin
          start = 1'b1;
          next_r.pulse_power = 1'b0;
          next_r.restart_after = 1'b1;
        end else if (r.power_fn[host_cmd_pkg::FN_KEY_POWER_ON] && !r.sense_s2
                     && r.confirm_ticks >= host_cmd_pkg::HOLD_SHORT_TICKS) begin
          start = 1'b1;
          next_r.pulse_power = 1'b1;
          next_r.restart_after = 1'b1;
        end else if (r.power_fn[host_cmd_pkg::FN_KEY_POWER_OFF] && r.sense_s2
                     && r.cancel_ticks >= host_cmd_pkg::HOLD_LONG_TICKS) begin
          start = 1'b1;
          next_r.pulse_power = 1'b1;
          next_r.restart_after = 1'b0;
          next_r.hold_ext = 1'b1;
        end
        if (start) begin
          next_r.mode = host_cmd_pkg::ST_PULSE;
          next_r.pulse_ticks = '0;
          next_r.ext_ticks = '0;
          next_r.pulse_sense = r.sense_s2;
          next_r.wait_release = 1'b1;
          next_r.rst_drive = ~next_r.pulse_power;
          next_r.pwr_drive = next_r.pulse_power;
        end
      end
      host_cmd_pkg::ST_PULSE: begin
        if (!r.pulse_power) lim = host_cmd_pkg::RESET_PULSE_TICKS;
        else if (r.pulse_len == host_cmd_pkg::PULSE_HOLD) lim = host_cmd_pkg::PULSE_HOLD_MAX_TICKS;
        else lim = {1'b0, r.pulse_len};
        base_done = (r.pulse_ticks >= lim)
                    || (r.pulse_power && r.pulse_len == host_cmd_pkg::PULSE_HOLD && r.sense_s2 != r.pulse_sense);
        if (!base_done) begin
          if (r.tick) next_r.pulse_ticks = r.pulse_ticks + 1'b1;
        end else if (r.hold_ext && cancel_held && r.ext_ticks < host_cmd_pkg::EXTEND_TICKS) begin
          if (r.tick) next_r.ext_ticks = r.ext_ticks + 1'b1;
        end else begin
          next_r.rst_drive = 1'b0;
          next_r.pwr_drive = 1'b0;
          next_r.hold_ext = 1'b0;
          next_r.pulse_ticks = '0;
          next_r.mode = r.restart_after ? host_cmd_pkg::ST_RESTART : host_cmd_pkg::ST_IDLE;
        end
      end
      host_cmd_pkg::ST_RESTART: begin
        // restart reloads power-up state of the volatile settings
        next_r.wd_timeout = '0;
        next_r.wd_ticks = '0;
        next_r.press_mask = host_cmd_pkg::KEY_MASK_RST;
        next_r.release_mask = host_cmd_pkg::KEY_MASK_RST;
        next_r.pressed_acc = '0;
        next_r.released_acc = '0;
        next_r.resp_valid = 1'b0;
        if (r.tick) next_r.pulse_ticks = r.pulse_ticks + 1'b1;
        if (r.pulse_ticks >= host_cmd_pkg::RESTART_TICKS) next_r.mode = host_cmd_pkg::ST_IDLE;
      end
      default: next_r.mode = host_cmd_pkg::ST_IDLE;
    endcase

    ////////////////////////////////////////////////////////////////////////
    // line polarity and mimicry outputs
    // auto polarity has no detector here: it settles on active low
    next_r.rst_level = r.power_fn[host_cmd_pkg::FN_AUTO_POL] ? 1'b0 : r.power_fn[host_cmd_pkg::FN_RESET_HIGH];
    next_r.pwr_level = r.power_fn[host_cmd_pkg::FN_AUTO_POL] ? 1'b0 : r.power_fn[host_cmd_pkg::FN_POWER_HIGH];
    host_off = r.power_fn[host_cmd_pkg::FN_DISPLAY_FOLLOW] & ~r.sense_s2;
    next_r.disp_en = ~host_off;
    next_r.leds_en = ~(host_off & r.power_fn[host_cmd_pkg::FN_LEDS_FOLLOW]);
    next_r.disp_out = host_off ? 7'h00 : r.disp_bl;
    next_r.key_out = host_off ? 7'h00 : r.key_bl;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.contrast <= host_cmd_pkg::CONTRAST_RST;
      r.disp_bl <= host_cmd_pkg::BRIGHT_RST;
      r.key_bl <= host_cmd_pkg::BRIGHT_RST;
      r.press_mask <= host_cmd_pkg::KEY_MASK_RST;
      r.release_mask <= host_cmd_pkg::KEY_MASK_RST;
      r.power_fn <= host_cmd_pkg::POWER_FN_RST;
      r.pulse_len <= host_cmd_pkg::PULSE_LEN_RST;
      r.mode <= host_cmd_pkg::ST_IDLE;
      r.disp_en <= 1'b1;
      r.leds_en <= 1'b1;
      r.disp_out <= host_cmd_pkg::BRIGHT_RST;
      r.key_out <= host_cmd_pkg::BRIGHT_RST;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign reset_line_o = r.rst_level;
  assign reset_line_oe = r.rst_drive;
  assign power_line_o = r.pwr_level;
  assign power_line_oe = r.pwr_drive;
  assign contrast_level = r.contrast;
  assign display_brightness = r.disp_out;
  assign keypad_brightness = r.key_out;
  assign display_on = r.disp_en;
  assign leds_on = r.leds_en;
  assign key_press_report = r.rep_press;
  assign key_release_report = r.rep_release;
  assign restarting = (r.mode == host_cmd_pkg::ST_RESTART);

endmodule : host_cmd_keypad_power_watchdog

// ### tb/host_cmd_monitor.sv
/* checker for the command block: bus stall, host line pulses, restart and blanking.
   assumes clk_en stays high and the module is bound to the block's top. */
`timescale 1ns/1ps
module host_cmd_monitor #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic sys_clk, // clock
  input wire logic rst_n, // async reset
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic avs_waitrequest, // stall
  input wire logic [5:0] key_pins, // keys
  input wire logic [5:0] key_press_report, // press events
  input wire logic reset_line_oe, // reset line driven
  input wire logic power_line_oe, // power line driven
  input wire logic [6:0] display_brightness, // display level
  input wire logic [6:0] keypad_brightness, // keypad level
  input wire logic display_on, // display shown
  input wire logic leds_on, // leds allowed
  input wire logic restarting // restart running
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  int unsigned held;
  // cycles the reset line has been driven so far
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n) held <= 0;
    else held <= reset_line_oe ? held + 1 : 0;
  ////////////////////////////////////////
  chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus stalled more than one cycle");
  chk_reset_len: assert property ($fell(reset_line_oe) |-> held >= 31 * TICK_CYCLES && held <= 32 * TICK_CYCLES + 1)
    else $error("reset pulse length wrong");
  chk_reset_restart: assert property ($fell(reset_line_oe) |-> ##[0:2] restarting)
    else $error("no restart after reset pulse");
  chk_lines_released: assert property (restarting && $past(restarting) |-> !reset_line_oe && !power_line_oe)
    else $error("host line driven during restart");
  // a pin change reaches the report three edges later: two sync stages and the edge register
  chk_press_held: assert property ((key_press_report & ~$past(key_pins, 3)) == 6'h00)
    else $error("press reported for a key not held");
  chk_blank_dark: assert property (!display_on && !$past(display_on) |-> display_brightness == 7'h00 && keypad_brightness == 7'h00)
    else $error("backlight lit while blanked");
  chk_leds_need_disp: assert property (!leds_on |-> !display_on)
    else $error("leds off without display blanking");
  chk_bright_range: assert property (display_brightness <= 7'h64 && keypad_brightness <= 7'h64)
    else $error("brightness above range");
  cover property ($rose(reset_line_oe));
  cover property ($rose(power_line_oe));
  cover property ($fell(restarting));
endmodule : host_cmd_monitor
bind host_cmd_keypad_power_watchdog host_cmd_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (.sys_clk, .rst_n, .avs_read,
  .avs_write, .avs_waitrequest, .key_pins, .key_press_report, .reset_line_oe, .power_line_oe, .display_brightness,
  .keypad_brightness, .display_on, .leds_on, .restarting);

// ### tb/host_supply_model.sv
/* host supply model: the host's power switch input and its power sense output.
   assumes the block pulses the power line to flip the supply, as a front switch. */
`timescale 1ns/1ps
module host_supply_model (
  input wire logic sys_clk, // clock
  input wire logic rst_n, // reset, host starts off
  input wire logic power_line_oe, // power line driven
  output logic host_sense_pin // host supply sense
);
  // a released line is no press; the supply flips when the pulse ends
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n) host_sense_pin <= 1'b0;
    else if ($fell(power_line_oe)) host_sense_pin <= ~host_sense_pin;
endmodule : host_supply_model

// ### tb/tb.sv
/* testbench for the command block: registers over Avalon-MM, keys, host supply model.
   assumes TICK_CYCLES shortened to 4, so one second is 128 clocks. */
`timescale 1ns/1ps
module tb;
  logic sys_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, host_sense_pin, avs_waitrequest;
  logic reset_line_o, reset_line_oe, power_line_o, power_line_oe, display_on, leds_on, restarting;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [5:0] key_pins = 6'h00, key_press_report, key_release_report, press_acc = 6'h00, rel_acc = 6'h00;
  logic [7:0] contrast_level;
  logic [6:0] display_brightness, keypad_brightness;
  logic [33:0] r;
  int failures = 0, samples_checked = 0, n;
  wire logic [2:0] mon = {restarting, reset_line_oe, power_line_oe};
  host_cmd_keypad_power_watchdog #(.TICK_CYCLES(4)) u_dut (.sys_clk, .rst_n, .clk_en(1'b1), .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .key_pins, .host_sense_pin,
    .reset_line_o, .reset_line_oe, .power_line_o, .power_line_oe, .contrast_level, .display_brightness,
    .keypad_brightness, .display_on, .leds_on, .key_press_report, .key_release_report, .restarting);
  host_supply_model u_host (.sys_clk, .rst_n, .power_line_oe, .host_sense_pin);
  initial forever #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    press_acc <= press_acc | key_press_report;
    rel_acc <= rel_acc | key_release_report;
  end
  ////////////////////////////////////////
  task automatic check(input string what, input logic [33:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= !w;
    // looked at in the edge's active step, so the value seen is the one from before that edge
    do begin @(posedge sys_clk); k++; end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50) failures++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task automatic cmd(input logic [7:0] t, input logic [1:0] len, input logic [15:0] d);
    logic [31:0] h;
    bus(1'b1, host_cmd_pkg::OFS_CMD, {d, 6'h00, len, t}, h);
    bus(1'b0, host_cmd_pkg::OFS_RESP_HDR, 32'h0, h);
    bus(1'b0, host_cmd_pkg::OFS_RESP_DATA, 32'h0, q);
    r = {h[9:0], q[23:0] & ~(24'hFFFFFF << (8 * h[9:8]))};
  endtask : cmd
  task automatic wait_sig(input int i, input logic v, input int lim);
    n = 0;
    while (mon[i] !== v && n < lim) begin @(posedge sys_clk); #1; n++; end
    if (n >= lim) failures++;
  endtask : wait_sig
  ////////////////////////////////////////
  task automatic t_reset_values();
    cmd(8'h0D, 2'd0, 16'h0); check("contrast", r, {10'h14D, 24'h00007F});
    cmd(8'h0E, 2'd0, 16'h0); check("backlights", r, {10'h24E, 24'h006464});
    cmd(8'h17, 2'd0, 16'h0); check("masks", r, {10'h257, 24'h003F3F});
    cmd(8'h1C, 2'd0, 16'h0); check("power fn", r, {10'h25C, 24'h00FF01});
    cmd(8'h1D, 2'd0, 16'h0); check("watchdog", r, {10'h15D, 24'h000000});
    bus(1'b0, 4'h2, 32'h0, q); check("unmapped", q, 32'h0);
  endtask : t_reset_values
  task automatic t_lights();
    cmd(8'h0D, 2'd1, 16'h00FF); check("contrast ack", r, {10'h04D, 24'h0});
    check("contrast out", contrast_level, 8'hFF);
    cmd(8'h0E, 2'd1, 16'h0032); check("one byte", {display_brightness, keypad_brightness}, 14'h1932);
    cmd(8'h0E, 2'd2, 16'h000A); check("two ack", r, {10'h04E, 24'h0});
    check("two out", {display_brightness, keypad_brightness}, 14'h0500);
    cmd(8'h0E, 2'd1, 16'h0065); check("too bright", r, {10'h0CE, 24'h0});
    cmd(8'h0E, 2'd0, 16'h0); check("kept", r, {10'h24E, 24'h00000A});
  endtask : t_lights
  task automatic t_keys();
    cmd(8'h17, 2'd2, 16'h0001); check("mask ack", r, {10'h057, 24'h0});
    @(posedge sys_clk) key_pins <= 6'h03;
    repeat (10) @(posedge sys_clk);
    key_pins <= 6'h00;
    repeat (10) @(posedge sys_clk);
    check("press events", press_acc, 6'h01);
    check("release events", rel_acc, 6'h00);
    cmd(8'h18, 2'd0, 16'h0); check("poll", r, {10'h358, 24'h030300});
    cmd(8'h18, 2'd0, 16'h0); check("poll again", r, {10'h358, 24'h0});
    cmd(8'h17, 2'd2, 16'h0040); check("bad mask", r, {10'h0D7, 24'h0});
  endtask : t_keys
  task automatic t_power_on();
    cmd(8'h1C, 2'd2, 16'h0258); check("fn ack", r, {10'h05C, 24'h0});
    repeat (4) @(posedge sys_clk);
    check("blanked", {display_on, leds_on, display_brightness}, 9'h0);
    @(posedge sys_clk) key_pins <= 6'h02;
    wait_sig(0, 1'b1, 200);
    check("power level", power_line_o, 1'b0);
    @(posedge sys_clk) key_pins <= 6'h00;
    wait_sig(0, 1'b0, 100);
    check("pulse length", n >= 6 && n <= 8, 1'b1);
    wait_sig(2, 1'b1, 20);
    check("restart", restarting, 1'b1);
    wait_sig(2, 1'b0, 400);
    check("display back", display_on, 1'b1);
  endtask : t_power_on
  task automatic t_watchdog();
    cmd(8'h1D, 2'd1, 16'h0001); check("wd ack", r, {10'h05D, 24'h0});
    wait_sig(1, 1'b1, 400);
    check("reset level", {reset_line_oe, reset_line_o}, 2'b10);
    wait_sig(2, 1'b1, 400);
    wait_sig(2, 1'b0, 400);
    cmd(8'h1D, 2'd0, 16'h0); check("wd cleared", r, {10'h15D, 24'h0});
  endtask : t_watchdog
  // host is on here; 4 s of hold is 512 clocks at the shortened tick
  task automatic t_keypad_lines();
    cmd(8'h1C, 2'd1, 16'h00A0); check("fn keys", r, {10'h05C, 24'h0});
    @(posedge sys_clk) key_pins <= 6'h02;
    wait_sig(1, 1'b1, 700);
    check("key reset", {n > 500, reset_line_oe, reset_line_o}, 3'b110);
    @(posedge sys_clk) key_pins <= 6'h00;
    wait_sig(2, 1'b1, 200);
    wait_sig(2, 1'b0, 200);
    check("reset done", {reset_line_oe, restarting}, 2'b00);
    @(posedge sys_clk) key_pins <= 6'h04;
    wait_sig(0, 1'b1, 700);
    repeat (100) @(posedge sys_clk);
    check("off extended", {n > 500, power_line_oe, restarting}, 3'b110);
    @(posedge sys_clk) key_pins <= 6'h00;
    wait_sig(0, 1'b0, 20);
    check("off ends", {n < 20, restarting}, 2'b10);
  endtask : t_keypad_lines
  task automatic summarize();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset_values();
    t_lights();
    t_keys();
    t_power_on();
    t_watchdog();
    t_keypad_lines();
    summarize();
  end
  initial begin
    #5_000_000;
    failures++;
    summarize();
  end
endmodule : tb
